// >>> rtl/rsp_pkg.sv
// Shared constants of the two-wire register port and its bus master.
package rsp_pkg;
  // Identifier value is arbitrary.
  localparam logic [6:0] DEV_ID    = 7'h2a;
  localparam logic       DIR_RD    = 1'h1;
  localparam logic       DIR_WR    = 1'h0;
  localparam int         PTR_W     = 5;
  localparam int         REG_N     = 32;
  localparam logic [3:0] ACK_BIT   = 4'h8;
  localparam logic [3:0] ACK_SEEN  = 4'h9;
  localparam logic [4:0] PTR_RESET = 5'h00;
  localparam logic [2:0] ARM_CYC   = 3'h4;
  localparam int         CLK_HZ    = 125_000_000;
  localparam int         SCL_HZ    = 400_000;
  localparam logic [6:0] QTR_CYC   = 7'(CLK_HZ / (SCL_HZ * 4));
endpackage

// >>> rtl/rsp_link_if.sv
// Open-drain serial link between the bus master and the register port.
`timescale 1ns/1ns
interface rsp_link_if;
  logic scl_o;
  logic scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;

  // Both lines are pulled up; any enabled low driver wins.
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~(m_sda_oe & ~m_sda_o) & ~(s_sda_oe & ~s_sda_o);

  modport master (output scl_o, scl_oe, m_sda_o, m_sda_oe,
                  input scl, sda);
  modport slave  (output s_sda_o, s_sda_oe, input scl, sda);
endinterface

// >>> rtl/rsp_slave.sv
// Two-wire slave port onto a 32-byte clock/control register array.
`timescale 1ns/1ns
module rsp_slave (
  input  wire logic        sys_clk,   // System clock, 125 MHz.
  input  wire logic        rst,       // Synchronous reset, active high.
  rsp_link_if.slave        link,      // Serial link to the master.
  input  wire logic [4:0]  loc_addr,  // Local read address.
  output logic      [7:0]  loc_rdata, // Local read data, one cycle late.
  output logic             wr_pulse,  // One cycle per byte written.
  output logic      [4:0]  wr_addr,   // Location of the written byte.
  output logic      [7:0]  wr_data,   // Value of the written byte.
  output logic             sel        // Addressed in the current transfer.
);
  typedef enum logic [7:0] {
    S_IDLE   = 8'h01,
    S_ID     = 8'h02,
    S_ACK_ID = 8'h04,
    S_RX     = 8'h08,
    S_ACK_RX = 8'h10,
    S_TX     = 8'h20,
    S_RACK   = 8'h40,
    S_SKIP   = 8'h80
  } rsp_sl_st_t;

  // ----------------------------------------------------------------
  // Pin synchronisers and line events
  // ----------------------------------------------------------------
  logic scl_m_q, scl_s_q, scl_p_q;
  logic sda_m_q, sda_s_q, sda_p_q;
  logic scl_rise, scl_fall, start_ev, stop_ev;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scl_m_q <= 1'h1;
      scl_s_q <= 1'h1;
      scl_p_q <= 1'h1;
      sda_m_q <= 1'h1;
      sda_s_q <= 1'h1;
      sda_p_q <= 1'h1;
    end else begin
      scl_m_q <= link.scl;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= link.sda;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end

  assign scl_rise = scl_s_q & ~scl_p_q;
  assign scl_fall = ~scl_s_q & scl_p_q;
  // Data edges while the clock stays high are framing, not data.
  assign start_ev = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign stop_ev  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

  // ----------------------------------------------------------------
  // Power-up guard
  // ----------------------------------------------------------------
  // The synchronisers hold reset values for a few cycles; edges seen
  // before they fill are not real bus events.
  logic [2:0] arm_q, arm_d;
  logic       armed;

  assign armed = (arm_q == rsp_pkg::ARM_CYC);

  always_comb begin
    arm_d = arm_q;
    if (!armed) begin
      arm_d = arm_q + 3'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      arm_q <= 3'h0;
    end else begin
      arm_q <= arm_d;
    end
  end

  // ----------------------------------------------------------------
  // Register array
  // ----------------------------------------------------------------
  logic [7:0] mem_q [rsp_pkg::REG_N];
  logic       mem_we;
  logic [4:0] mem_wa;
  logic [7:0] mem_wd;

  always_ff @(posedge sys_clk) begin
    if (mem_we) begin
      mem_q[mem_wa] <= mem_wd;
    end
    loc_rdata <= mem_q[loc_addr];
  end

  // ----------------------------------------------------------------
  // Protocol engine
  // ----------------------------------------------------------------
  rsp_sl_st_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic [4:0] ptr_q, ptr_d;
  logic       oe_q, oe_d;
  logic       rd_q, rd_d;
  logic       isaddr_q, isaddr_d;
  logic       ack_q, ack_d;
  logic       wrp_d;
  logic       load;

  always_comb begin
    st_d     = st_q;
    cnt_d    = cnt_q;
    sh_d     = sh_q;
    ptr_d    = ptr_q;
    oe_d     = oe_q;
    rd_d     = rd_q;
    isaddr_d = isaddr_q;
    ack_d    = ack_q;
    wrp_d    = 1'h0;
    mem_we   = 1'h0;
    mem_wa   = ptr_q;
    mem_wd   = sh_q;
    load     = 1'h0;
    if (!armed) begin
      st_d = S_IDLE;
    end else if (stop_ev) begin
      st_d = S_IDLE;
      oe_d = 1'h0;
    end else if (start_ev) begin
      st_d  = S_ID;
      cnt_d = 4'h0;
      oe_d  = 1'h0;
    end else begin
      case (st_q)
        S_ID: begin
          if (scl_rise) begin
            sh_d  = {sh_q[6:0], sda_s_q};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == rsp_pkg::ACK_BIT) begin
            if (sh_q[7:1] == rsp_pkg::DEV_ID) begin
              oe_d = 1'h1;
              rd_d = (sh_q[0] == rsp_pkg::DIR_RD);
              st_d = S_ACK_ID;
            end else begin
              st_d = S_SKIP;
            end
          end
        end
        S_ACK_ID: begin
          if (scl_rise) begin
            cnt_d = rsp_pkg::ACK_SEEN;
          end else if (scl_fall && cnt_q == rsp_pkg::ACK_SEEN) begin
            if (rd_q) begin
              load = 1'h1;
            end else begin
              oe_d     = 1'h0;
              cnt_d    = 4'h0;
              isaddr_d = 1'h1;
              st_d     = S_RX;
            end
          end
        end
        S_RX: begin
          if (scl_rise) begin
            sh_d  = {sh_q[6:0], sda_s_q};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == rsp_pkg::ACK_BIT) begin
            oe_d = 1'h1;
            st_d = S_ACK_RX;
            if (isaddr_q) begin
              ptr_d = sh_q[4:0];
            end else begin
              mem_we = 1'h1;
              wrp_d  = 1'h1;
              ptr_d  = ptr_q + 5'h01;
            end
          end
        end
        S_ACK_RX: begin
          if (scl_rise) begin
            cnt_d = rsp_pkg::ACK_SEEN;
          end else if (scl_fall && cnt_q == rsp_pkg::ACK_SEEN) begin
            oe_d     = 1'h0;
            cnt_d    = 4'h0;
            isaddr_d = 1'h0;
            st_d     = S_RX;
          end
        end
        S_TX: begin
          if (scl_rise) begin
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (cnt_q == rsp_pkg::ACK_BIT) begin
              oe_d = 1'h0;
              st_d = S_RACK;
            end else begin
              sh_d = {sh_q[6:0], 1'h0};
              oe_d = ~sh_q[6];
            end
          end
        end
        S_RACK: begin
          if (scl_rise) begin
            ack_d = ~sda_s_q;
            cnt_d = rsp_pkg::ACK_SEEN;
          end else if (scl_fall && cnt_q == rsp_pkg::ACK_SEEN) begin
            if (ack_q) begin
              load = 1'h1;
            end else begin
              st_d = S_SKIP;
            end
          end
        end
        S_IDLE, S_SKIP: begin
          oe_d = 1'h0;
        end
        default: begin
          st_d = S_IDLE;
          oe_d = 1'h0;
        end
      endcase
    end
    if (load) begin
      sh_d  = mem_q[ptr_q];
      ptr_d = ptr_q + 5'h01;
      cnt_d = 4'h0;
      oe_d  = ~mem_q[ptr_q][7];
      st_d  = S_TX;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q     <= S_IDLE;
      cnt_q    <= 4'h0;
      sh_q     <= 8'h00;
      ptr_q    <= rsp_pkg::PTR_RESET;
      oe_q     <= 1'h0;
      rd_q     <= 1'h0;
      isaddr_q <= 1'h0;
      ack_q    <= 1'h0;
      wr_pulse <= 1'h0;
      wr_addr  <= 5'h00;
      wr_data  <= 8'h00;
    end else begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      sh_q     <= sh_d;
      ptr_q    <= ptr_d;
      oe_q     <= oe_d;
      rd_q     <= rd_d;
      isaddr_q <= isaddr_d;
      ack_q    <= ack_d;
      wr_pulse <= wrp_d;
      if (wrp_d) begin
        wr_addr <= ptr_q;
        wr_data <= sh_q;
      end
    end
  end

  // The device never drives the clock and only pulls data low.
  assign link.s_sda_o  = 1'h0;
  assign link.s_sda_oe = oe_q;
  assign sel = ~(st_q == S_IDLE || st_q == S_SKIP || st_q == S_ID);
endmodule

// >>> rtl/rsp_master.sv
// Bus master that writes and random-reads the register port.
`timescale 1ns/1ns
module rsp_master (
  input  wire logic        sys_clk,   // System clock, 125 MHz.
  input  wire logic        rst,       // Synchronous reset, active high.
  rsp_link_if.master       link,      // Serial link to the device.
  input  wire logic        cmd_valid, // Command offered.
  output logic             cmd_ready, // Command taken when both high.
  input  wire logic        cmd_rd,    // 1 random read, 0 single write.
  input  wire logic [7:0]  cmd_reg,   // Register address.
  input  wire logic [7:0]  cmd_wdata, // Write data.
  input  wire logic [7:0]  cmd_len,   // Bytes to read, 0 counts as 1.
  output logic             rd_valid,  // Read byte available.
  input  wire logic        rd_ready,  // Read byte consumed.
  output logic      [7:0]  rd_data,   // Read byte.
  output logic             nack_err,  // Pulse: device did not ack.
  output logic             busy       // Transfer in progress.
);
  typedef enum logic [8:0] {
    M_IDLE  = 9'h001,
    M_START = 9'h002,
    M_ID    = 9'h004,
    M_REG   = 9'h008,
    M_WD    = 9'h010,
    M_RSTRT = 9'h020,
    M_ID2   = 9'h040,
    M_RX    = 9'h080,
    M_STOP  = 9'h100
  } rsp_ms_st_t;

  // ----------------------------------------------------------------
  // Data line synchroniser
  // ----------------------------------------------------------------
  logic sda_m_q, sda_s_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sda_m_q <= 1'h1;
      sda_s_q <= 1'h1;
    end else begin
      sda_m_q <= link.sda;
      sda_s_q <= sda_m_q;
    end
  end

  // ----------------------------------------------------------------
  // Two-entry read buffer
  // ----------------------------------------------------------------
  logic [7:0] fb_q [2];
  logic [7:0] sh_q, sh_d;
  logic       err_q;
  logic       wp_q, rp_q;
  logic [1:0] fc_q;
  logic       push, pop, full;

  assign full     = (fc_q == 2'h2);
  assign rd_valid = (fc_q != 2'h0);
  assign rd_data  = fb_q[rp_q];
  assign pop      = rd_valid & rd_ready;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wp_q <= 1'h0;
      rp_q <= 1'h0;
      fc_q <= 2'h0;
    end else begin
      if (push) begin
        fb_q[wp_q] <= sh_q;
        wp_q       <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      fc_q <= fc_q + {1'h0, push} - {1'h0, pop};
    end
  end

  // ----------------------------------------------------------------
  // Quarter-bit sequencer
  // ----------------------------------------------------------------
  rsp_ms_st_t st_q, st_d;
  logic [6:0] tck_q, tck_d;
  logic [1:0] q_q, q_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] left_q, left_d;
  logic [7:0] reg_q, reg_d;
  logic [7:0] wd_q, wd_d;
  logic       rd_q, rd_d;
  logic       scl_oe_q, scl_oe_d;
  logic       sda_oe_q, sda_oe_d;
  logic       err_d;
  logic       tick;
  logic       txs;
  rsp_ms_st_t nxt;
  logic [7:0] nxt_sh;

  assign tick = (tck_q == rsp_pkg::QTR_CYC - 7'h01);
  assign txs  = (st_q == M_ID) || (st_q == M_REG) ||
                (st_q == M_WD) || (st_q == M_ID2);
  assign cmd_ready = (st_q == M_IDLE);

  always_comb begin
    st_d = st_q;  tck_d = tick ? 7'h00 : tck_q + 7'h01;
    q_d = q_q;  bit_d = bit_q;  sh_d = sh_q;  left_d = left_q;
    reg_d = reg_q;  wd_d = wd_q;  rd_d = rd_q;
    scl_oe_d = scl_oe_q;  sda_oe_d = sda_oe_q;
    err_d = 1'h0;  push = 1'h0;
    nxt = M_STOP;  nxt_sh = 8'h00;
    case (st_q)
      M_ID:    begin nxt = M_REG;  nxt_sh = reg_q; end
      M_REG:   begin
        nxt    = rd_q ? M_RSTRT : M_WD;
        nxt_sh = wd_q;
      end
      M_WD:    nxt = M_STOP;
      M_ID2:   nxt = M_RX;
      default: nxt = M_STOP;
    endcase
    if (st_q == M_IDLE) begin
      tck_d = 7'h00;
      q_d   = 2'h0;
      if (cmd_valid) begin
        st_d   = M_START;
        reg_d  = cmd_reg;
        wd_d   = cmd_wdata;
        rd_d   = cmd_rd;
        left_d = (cmd_len == 8'h00) ? 8'h01 : cmd_len;
      end
    end else if (tick) begin
      q_d = q_q + 2'h1;
      case (st_q)
        M_START, M_RSTRT: begin
          case (q_q)
            2'h0:    sda_oe_d = 1'h0;
            2'h1:    scl_oe_d = 1'h0;
            2'h2:    sda_oe_d = 1'h1;
            default: begin
              scl_oe_d = 1'h1;
              bit_d    = 4'h0;
              st_d     = (st_q == M_START) ? M_ID : M_ID2;
              // Same identifier in both phases, direction differs.
              sh_d = {rsp_pkg::DEV_ID,
                      (st_q == M_START) ? rsp_pkg::DIR_WR
                                        : rsp_pkg::DIR_RD};
            end
          endcase
        end
        M_STOP: begin
          case (q_q)
            2'h0:    sda_oe_d = 1'h1;
            2'h1:    scl_oe_d = 1'h0;
            2'h2:    sda_oe_d = 1'h0;
            default: st_d = M_IDLE;
          endcase
        end
        M_RX: begin
          case (q_q)
            2'h0: begin
              if (bit_q == rsp_pkg::ACK_BIT) begin
                if (full) begin
                  q_d = q_q; // Hold the clock low until space frees.
                end else begin
                  push     = 1'h1;
                  sda_oe_d = (left_q != 8'h01);
                end
              end else begin
                sda_oe_d = 1'h0;
              end
            end
            2'h1: scl_oe_d = 1'h0;
            2'h2: begin
              scl_oe_d = 1'h1;
              if (bit_q != rsp_pkg::ACK_BIT) begin
                sh_d = {sh_q[6:0], sda_s_q};
              end
            end
            default: begin
              if (bit_q != rsp_pkg::ACK_BIT) begin
                bit_d = bit_q + 4'h1;
              end else if (left_q != 8'h01) begin
                left_d = left_q - 8'h01;
                bit_d  = 4'h0;
              end else begin
                st_d = M_STOP;
              end
            end
          endcase
        end
        default: begin
          if (txs) begin
            case (q_q)
              2'h0: begin
                sda_oe_d = (bit_q != rsp_pkg::ACK_BIT) & ~sh_q[7];
              end
              2'h1: scl_oe_d = 1'h0;
              2'h2: begin
                scl_oe_d = 1'h1;
                if (bit_q == rsp_pkg::ACK_BIT && sda_s_q) begin
                  err_d = 1'h1;
                end
              end
              default: begin
                if (bit_q != rsp_pkg::ACK_BIT) begin
                  sh_d  = {sh_q[6:0], 1'h0};
                  bit_d = bit_q + 4'h1;
                end else begin
                  bit_d = 4'h0;
                  sh_d  = nxt_sh;
                  st_d  = err_q ? M_STOP : nxt;
                end
              end
            endcase
          end else begin
            st_d = M_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q     <= M_IDLE;
      tck_q    <= 7'h00;
      q_q      <= 2'h0;
      bit_q    <= 4'h0;
      sh_q     <= 8'h00;
      left_q   <= 8'h00;
      reg_q    <= 8'h00;
      wd_q     <= 8'h00;
      rd_q     <= 1'h0;
      scl_oe_q <= 1'h0;
      sda_oe_q <= 1'h0;
      err_q    <= 1'h0;
      nack_err <= 1'h0;
    end else begin
      st_q     <= st_d;
      tck_q    <= tck_d;
      q_q      <= q_d;
      bit_q    <= bit_d;
      sh_q     <= sh_d;
      left_q   <= left_d;
      reg_q    <= reg_d;
      wd_q     <= wd_d;
      rd_q     <= rd_d;
      scl_oe_q <= scl_oe_d;
      sda_oe_q <= sda_oe_d;
      err_q    <= (st_d == M_IDLE) ? 1'h0 : (err_q | err_d);
      nack_err <= err_d;
    end
  end

  assign link.scl_o    = 1'h0;
  assign link.scl_oe   = scl_oe_q;
  assign link.m_sda_o  = 1'h0;
  assign link.m_sda_oe = sda_oe_q;
  assign busy          = (st_q != M_IDLE);
endmodule

// >>> bench/rsp_link_props.sv
// Concurrent checks on the serial link between the master and the port.
`timescale 1ns/1ns
module rsp_link_props (
  input wire logic sys_clk,  // System clock.
  input wire logic rst,      // Synchronous reset, active high.
  input wire logic scl_o,    // Master clock driver value.
  input wire logic scl_oe,   // Master pulls the clock low.
  input wire logic m_sda_o,  // Master data driver value.
  input wire logic m_sda_oe, // Master pulls the data low.
  input wire logic s_sda_o,  // Port data driver value.
  input wire logic s_sda_oe, // Port pulls the data low.
  input wire logic scl,      // Resolved clock line.
  input wire logic sda       // Resolved data line.
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ---------------------------------------------------------------
  // Bus tracker
  // ---------------------------------------------------------------
  logic       scl_q, sda_q, first_q, rd_q, nak_q, ok_q;
  logic       scl_d, sda_d, first_d, rd_d, nak_d, ok_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic       rise, start, stop;

  assign rise  = scl & ~scl_q;
  assign start = scl & scl_q & sda_q & ~sda;
  assign stop  = scl & scl_q & ~sda_q & sda;

  always_comb begin
    {scl_d, sda_d, first_d, rd_d, nak_d, ok_d} =
      {scl, sda, first_q, rd_q, nak_q, ok_q};
    cnt_d = cnt_q;
    sh_d  = sh_q;
    if (start || stop) begin
      {first_d, rd_d, nak_d, ok_d} = 4'h8;
      cnt_d = 4'h0;
    end else if (rise && cnt_q != rsp_pkg::ACK_BIT) begin
      cnt_d = cnt_q + 4'h1;
      sh_d  = {sh_q[6:0], sda};
    end else if (rise) begin
      cnt_d   = 4'h0;
      first_d = 1'b0;
      if (first_q) begin
        ok_d = sh_q[7:1] == rsp_pkg::DEV_ID;
        rd_d = sh_q[0] & (sh_q[7:1] == rsp_pkg::DEV_ID);
      end
      if (rd_q && sda) begin
        nak_d = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      {scl_q, sda_q, first_q, rd_q, nak_q, ok_q} <= 6'h30;
      cnt_q <= 4'h0;
      sh_q  <= 8'h00;
    end else begin
      {scl_q, sda_q, first_q, rd_q, nak_q, ok_q} <=
        {scl_d, sda_d, first_d, rd_d, nak_d, ok_d};
      cnt_q <= cnt_d;
      sh_q  <= sh_d;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  AST_RST_REL:
  assert property (disable iff (1'b0)
    rst |=> !s_sda_oe && !m_sda_oe && !scl_oe)
    else $error("link not released in reset");
  AST_GUARD:
  assert property ($fell(rst) |-> !s_sda_oe [*4])
    else $error("port drove data during power-up guard");
  AST_SLV_EDGE:
  assert property ($changed(s_sda_oe) |-> !scl && !$past(scl))
    else $error("port data changed near a high clock");
  AST_ID_ACK:
  assert property (rise && cnt_q == rsp_pkg::ACK_BIT && first_q |->
    (sda == 1'b0) == (sh_q[7:1] == rsp_pkg::DEV_ID))
    else $error("identifier acknowledge wrong");
  AST_WR_ACK:
  assert property (rise && cnt_q == rsp_pkg::ACK_BIT && !first_q &&
    !rd_q && ok_q |-> !sda)
    else $error("received byte not acknowledged");
  AST_SLV_RX_REL:
  assert property (rise && cnt_q != rsp_pkg::ACK_BIT && !rd_q |->
    !s_sda_oe)
    else $error("port drove data while receiving");
  AST_SLV_TX_REL:
  assert property (rise && cnt_q == rsp_pkg::ACK_BIT && rd_q |->
    !s_sda_oe)
    else $error("port held data in master acknowledge slot");
  AST_MST_RX_REL:
  assert property (rise && cnt_q != rsp_pkg::ACK_BIT && rd_q && !nak_q |->
    !m_sda_oe)
    else $error("master drove data during read bits");
  AST_NAK_REL:
  assert property (nak_q |-> !s_sda_oe)
    else $error("port drove data after missing acknowledge");
endmodule

// >>> bench/rtc_i2c_slave_register_port_test.sv
// Self-checking bench for the two-wire register port and its master.
`timescale 1ns/1ns
`define CHK(a, e) begin \
  n_checks++; \
  if ((a) !== (e)) begin \
    n_errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); \
  end \
end
module rtc_i2c_slave_register_port_test;
  logic       sys_clk   = 1'b0;
  logic       rst       = 1'b1;
  logic       cmd_valid = 1'b0;
  logic       cmd_rd    = 1'b0;
  logic       rd_ready  = 1'b0;
  logic [7:0] cmd_reg   = 8'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic [7:0] cmd_len   = 8'h00;
  logic [4:0] loc_addr  = 5'h00;
  logic       cmd_ready, rd_valid, nack_err, busy, wr_pulse, sel, sel2, ack;
  logic [7:0] rd_data, loc_rdata, loc_rdata2, wr_data, wr_data2;
  logic [4:0] wr_addr, wr_addr2;
  logic [7:0] mem_m [32];
  int         n_errors = 0;
  int         n_checks = 0;
  int         n_wr     = 0;
  int         n_nack   = 0;

  always #4 sys_clk = ~sys_clk;

  rsp_link_if link ();
  rsp_link_if link2 ();
  rsp_master rsp_master_inst (.sys_clk(sys_clk), .rst(rst),
    .link(link.master), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_rd(cmd_rd), .cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata),
    .cmd_len(cmd_len), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_data(rd_data), .nack_err(nack_err), .busy(busy));
  rsp_slave rsp_slave_inst (.sys_clk(sys_clk), .rst(rst),
    .link(link.slave), .loc_addr(loc_addr), .loc_rdata(loc_rdata),
    .wr_pulse(wr_pulse), .wr_addr(wr_addr), .wr_data(wr_data), .sel(sel));
  rsp_slave rsp_slave_inst2 (.sys_clk(sys_clk), .rst(rst),
    .link(link2.slave), .loc_addr(5'h00), .loc_rdata(loc_rdata2),
    .wr_pulse(), .wr_addr(wr_addr2), .wr_data(wr_data2), .sel(sel2));
  rsp_link_props rsp_link_props_inst (.sys_clk(sys_clk), .rst(rst),
    .scl_o(link.scl_o), .scl_oe(link.scl_oe), .m_sda_o(link.m_sda_o),
    .m_sda_oe(link.m_sda_oe), .s_sda_o(link.s_sda_o),
    .s_sda_oe(link.s_sda_oe), .scl(link.scl), .sda(link.sda));

  always @(posedge sys_clk) begin
    if (wr_pulse === 1'b1) n_wr++;
    if (nack_err === 1'b1) n_nack++;
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic wait_idle();
    for (int k = 0; busy !== 1'b0 && k < 40000; k++) tick();
  endtask

  task automatic issue(input logic rd, input logic [7:0] r, w, n);
    cmd_rd    = rd;
    cmd_reg   = r;
    cmd_wdata = w;
    cmd_len   = n;
    cmd_valid = 1'b1;
    for (int k = 0; cmd_ready !== 1'b1 && k < 40000; k++) tick();
    tick();
    cmd_valid = 1'b0;
    `CHK(busy, 1'b1)
  endtask

  task automatic wr(input logic [7:0] r, input logic [7:0] d);
    issue(1'b0, r, d, 8'h00);
    mem_m[r[4:0]] = d;
    wait_idle();
    `CHK(wr_addr, r[4:0])
    `CHK(wr_data, d)
    loc_addr = r[4:0];
    tick();
    tick();
    `CHK(loc_rdata, d)
  endtask

  // The consumer stalls first, so the two-entry buffer fills and the
  // master must hold the clock low until a word is taken.
  task automatic rd(input logic [7:0] r, input int n);
    issue(1'b1, r, 8'h00, 8'(n));
    for (int k = 0; rd_valid !== 1'b1 && k < 40000; k++) tick();
    repeat (6000) tick();
    `CHK(link.scl, 1'b0)
    rd_ready = 1'b1;
    for (int i = 0; i < n; i++) begin
      for (int k = 0; rd_valid !== 1'b1 && k < 40000; k++) tick();
      `CHK(rd_data, mem_m[5'(r + i)])
      tick();
    end
    rd_ready = 1'b0;
    wait_idle();
  endtask

  task automatic q();
    repeat (20) tick();
  endtask

  task automatic bb(input logic b, output logic r);
    link2.m_sda_oe = ~b;
    q();
    link2.scl_oe = 1'b0;
    q();
    r = link2.sda;
    q();
    link2.scl_oe = 1'b1;
    q();
  endtask

  task automatic bbyte(input logic [7:0] v, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) bb(v[i], r);
    bb(1'b1, a);
  endtask

  task automatic bstart();
    link2.m_sda_oe = 1'b0;
    q();
    link2.scl_oe = 1'b0;
    q();
    link2.m_sda_oe = 1'b1;
    q();
    link2.scl_oe = 1'b1;
    q();
  endtask

  task automatic bstop();
    link2.m_sda_oe = 1'b1;
    q();
    link2.scl_oe = 1'b0;
    q();
    link2.m_sda_oe = 1'b0;
    q();
  endtask

  task automatic stop_test();
    if (n_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    link2.scl_o    = 1'b0;
    link2.m_sda_o  = 1'b0;
    link2.scl_oe   = 1'b0;
    link2.m_sda_oe = 1'b0;
    repeat (4) tick();
    rst = 1'b0;
    `CHK(busy, 1'b0)
    `CHK(cmd_ready, 1'b1)
    `CHK(link.sda, 1'b1)
    `CHK(sel, 1'b0)
    repeat (8) tick();
    bstart();
    bbyte({rsp_pkg::DEV_ID ^ 7'h01, rsp_pkg::DIR_WR}, ack);
    `CHK(ack, 1'b1)
    bbyte(8'h00, ack);
    `CHK(ack, 1'b1)
    `CHK(sel2, 1'b0)
    bstart();
    bbyte({rsp_pkg::DEV_ID, rsp_pkg::DIR_WR}, ack);
    `CHK(ack, 1'b0)
    bbyte(8'h1f, ack);
    `CHK(ack, 1'b0)
    bbyte(8'h5a, ack);
    `CHK(ack, 1'b0)
    `CHK(wr_addr2, 5'h1f)
    bbyte(8'hc3, ack);
    `CHK(ack, 1'b0)
    `CHK(wr_addr2, 5'h00)
    `CHK(loc_rdata2, 8'hc3)
    bstop();
    `CHK(sel2, 1'b0)
    wr(8'h1e, 8'ha5);
    wr(8'h1f, 8'h3c);
    wr(8'he0, 8'h81);
    rd(8'h1e, 3);
    `CHK(n_wr, 3)
    `CHK(n_nack, 0)
    `CHK(sel, 1'b0)
    stop_test();
  end

  initial begin
    repeat (90000) @(posedge sys_clk);
    n_errors++;
    stop_test();
  end
endmodule
